// file: ptg_pkg.sv
// Constants, register map and types of the pacer and general timer block.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package ptg_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_DIV1 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_DIV2 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_GT_MODE = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_GT_COUNT = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLES = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_STOP_COUNT = 4'h8;

  // ==========================================================================
  // Field positions
  localparam int CTRL_TRIG_EN_BIT = 0;
  localparam int CTRL_EXT_CLK_BIT = 1;
  localparam int CMD_GT_STOP_BIT = 0;
  localparam int CMD_ACQ_STOP_BIT = 1;
  localparam int CMD_SAMPLES_CLR_BIT = 2;
  localparam int STAT_GT_OUT_BIT = 0;
  localparam int STAT_PACER_RUN_BIT = 1;
  localparam int STAT_TRIG_EN_BIT = 2;
  localparam int STAT_GT_ACTIVE_BIT = 3;
  localparam int MODE_W = 3;

  // ==========================================================================
  // Counter modes
  localparam logic [MODE_W-1:0] counter_mode_zero = 3'h0;
  localparam logic [MODE_W-1:0] counter_mode_one = 3'h1;
  localparam logic [MODE_W-1:0] counter_mode_two = 3'h2;
  localparam logic [MODE_W-1:0] counter_mode_three = 3'h3;
  localparam logic [MODE_W-1:0] counter_mode_four = 3'h4;
  localparam logic [MODE_W-1:0] counter_mode_five = 3'h5;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] DIV_RST = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] ONE = 16'h0001;
  localparam logic [DATA_W-1:0] TWO = 16'h0002;

  // ==========================================================================
  // Timing: 2 MHz tick made from 25 MHz by a fractional accumulator
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int PACER_SRC_HZ = 2_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int TICK_ACC_W = 5;
  localparam logic [TICK_ACC_W-1:0] TICK_STEP = TICK_ACC_W'(PACER_SRC_HZ / HZ_PER_MHZ);
  localparam logic [TICK_ACC_W-1:0] TICK_MOD = TICK_ACC_W'(SYS_CLK_HZ / HZ_PER_MHZ);

  // ==========================================================================
  // General timer sequencing
  typedef enum logic [1:0] {GT_IDLE, GT_ARMED, GT_RUN} ptg_gt_state_t;

endpackage : ptg_pkg

// file: ptg_pacer_if.sv
// Carrier between the timer top and the pacer divider chain.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface ptg_pacer_if;
  import ptg_pkg::*;
  logic tick;
  logic enable;
  logic [DATA_W-1:0] div1;
  logic [DATA_W-1:0] div2;
  logic trig;
  logic running;
  modport ctl (output tick, enable, div1, div2, input trig, running);
  modport pacer (input tick, enable, div1, div2, output trig, running);
endinterface : ptg_pacer_if

// file: ptg_pacer.sv
// Cascaded pacer dividers producing the conversion trigger.
// Assumes tick is a one-cycle 2 MHz enable on clk_sys.
`timescale 1ns/1ps
module ptg_pacer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control side
  ptg_pacer_if.pacer pif
);
  import ptg_pkg::*;

  logic [DATA_W-1:0] cnt1_r;
  logic [DATA_W-1:0] cnt2_r;
  logic trig_r;
  logic t1_end;
  logic t2_end;

  // ==========================================================================
  // Run condition: any zero divider halts the chain
  assign pif.running = pif.enable && (pif.div1 != DIV_RST) && (pif.div2 != DIV_RST);
  assign t1_end = pif.running && pif.tick && (cnt1_r <= ONE);
  assign t2_end = t1_end && (cnt2_r <= ONE);
  assign pif.trig = trig_r;

  // ==========================================================================
  // First divider counts ticks, second counts first-divider ends
  always_ff @(posedge clk_sys) begin
    if (rst || !pif.running) begin
      cnt1_r <= pif.div1;
    end else if (pif.tick) begin
      cnt1_r <= (cnt1_r <= ONE) ? pif.div1 : cnt1_r - ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !pif.running) begin
      cnt2_r <= pif.div2;
    end else if (t1_end) begin
      cnt2_r <= (cnt2_r <= ONE) ? pif.div2 : cnt2_r - ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= t2_end;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_pacer_halt;
    !pif.running |=> !pif.trig;
  endproperty
  a_pacer_halt: assert property (p_pacer_halt) else $error("pacer trigger while halted");

  property p_trig_single;
    pif.trig |=> !pif.trig;
  endproperty
  a_trig_single: assert property (p_trig_single) else $error("pacer trigger longer than one cycle");

  property p_trig_on_tick;
    pif.trig |-> $past(pif.tick) && $past(pif.running);
  endproperty
  a_trig_on_tick: assert property (p_trig_on_tick) else $error("pacer trigger without source tick");

endmodule : ptg_pacer

// file: ptg_timer.sv
// Pacer trigger and general-purpose timer with a plain register port.
// Assumes a 25 MHz clk_sys, synchronous reset, and asynchronous timer pins.
//
// What this block does
// - Pacer rate is 2 MHz over divider product.
// - Pacer dividers serve only the sampling trigger.
// - Any zero divider stops pacer triggers.
// - General timer offers counter modes zero to five.
// - Internal clock generates; external clock counts events.
// - Current general timer count readable any time.
// - Stop parks one-shot, count zero, reports count.
// - Acquisition stop disables trigger, keeps sample count.
`timescale 1ns/1ps
module ptg_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [ptg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ptg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ptg_pkg::DATA_W-1:0] reg_rdata,
  // General timer pins
  input wire logic gt_ext_clk_in,
  input wire logic gt_gate_in,
  output logic gt_out,
  // Converter side
  input wire logic sample_done,
  output logic pacer_trig
);
  import ptg_pkg::*;

  ptg_pacer_if pif ();

  logic [TICK_ACC_W-1:0] tick_acc_r;
  logic tick_r;
  logic [DATA_W-1:0] first_pacer_divider_r;
  logic [DATA_W-1:0] second_pacer_divider_r;
  logic trig_en_r;
  logic ext_sel_r;
  logic [MODE_W-1:0] gt_mode_r;
  logic [DATA_W-1:0] general_timer_count_r;
  logic [DATA_W-1:0] gt_count_r;
  logic [DATA_W-1:0] stop_count_r;
  logic [DATA_W-1:0] samples_r;
  logic gt_out_r;
  ptg_gt_state_t gt_state_r;
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic gate_s1_r, gate_s2_r, gate_s3_r;
  logic gate_trig_r;
  logic [DATA_W-1:0] rdata_r;
  logic wr_div1, wr_div2, wr_ctrl, wr_mode, wr_count, wr_cmd;
  logic gt_stop, acq_stop, samples_clr;
  logic ext_rise, gate_rise, gt_tick, gate_lvl, hw_trig_mode, pulse_mode;

  // ==========================================================================
  // Write decode
  assign wr_div1 = reg_wr && (reg_addr == ADDR_DIV1);
  assign wr_div2 = reg_wr && (reg_addr == ADDR_DIV2);
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_mode = reg_wr && (reg_addr == ADDR_GT_MODE) && (reg_wdata[MODE_W-1:0] <= counter_mode_five);
  assign wr_count = reg_wr && (reg_addr == ADDR_GT_COUNT);
  assign wr_cmd = reg_wr && (reg_addr == ADDR_CMD);
  assign gt_stop = wr_cmd && reg_wdata[CMD_GT_STOP_BIT];
  assign acq_stop = wr_cmd && reg_wdata[CMD_ACQ_STOP_BIT];
  assign samples_clr = wr_cmd && reg_wdata[CMD_SAMPLES_CLR_BIT];

  // ==========================================================================
  // 2 MHz source tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_acc_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_acc_r + TICK_STEP >= TICK_MOD) begin
      tick_acc_r <= tick_acc_r + TICK_STEP - TICK_MOD;
      tick_r <= 1'b1;
    end else begin
      tick_acc_r <= tick_acc_r + TICK_STEP;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Pacer registers and divider chain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_pacer_divider_r <= DIV_RST;
      second_pacer_divider_r <= DIV_RST;
    end else begin
      if (wr_div1) begin
        first_pacer_divider_r <= reg_wdata;
      end
      if (wr_div2) begin
        second_pacer_divider_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trig_en_r <= 1'b0;
      ext_sel_r <= 1'b0;
    end else if (acq_stop) begin
      trig_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      trig_en_r <= reg_wdata[CTRL_TRIG_EN_BIT];
      ext_sel_r <= reg_wdata[CTRL_EXT_CLK_BIT];
    end
  end

  assign pif.tick = tick_r;
  assign pif.enable = trig_en_r;
  assign pif.div1 = first_pacer_divider_r;
  assign pif.div2 = second_pacer_divider_r;
  assign pacer_trig = pif.trig;

  // Dividers feed nothing but the conversion trigger
  ptg_pacer u_pacer (
    .clk_sys(clk_sys),
    .rst(rst),
    .pif(pif)
  );

  // Sample tally survives an acquisition stop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      samples_r <= COUNT_RST;
    end else if (sample_done) begin
      samples_r <= samples_clr ? ONE : samples_r + ONE;
    end else if (samples_clr) begin
      samples_r <= COUNT_RST;
    end
  end

  // ==========================================================================
  // Timer pin synchronisers and edge detect
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      gate_s1_r <= 1'b0;
      gate_s2_r <= 1'b0;
      gate_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= gt_ext_clk_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      gate_s1_r <= gt_gate_in;
      gate_s2_r <= gate_s1_r;
      gate_s3_r <= gate_s2_r;
    end
  end

  assign ext_rise = ext_s2_r && !ext_s3_r;
  assign gate_rise = gate_s2_r && !gate_s3_r;
  assign gate_lvl = gate_s2_r;
  assign gt_tick = ext_sel_r ? ext_rise : tick_r;
  assign hw_trig_mode = (gt_mode_r == counter_mode_one) || (gt_mode_r == counter_mode_five);
  assign pulse_mode = (gt_mode_r == counter_mode_two) || (gt_mode_r == counter_mode_four) ||
                      (gt_mode_r == counter_mode_five);

  // Gate rising edge held until the next timer tick
  // A fresh gate edge wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gate_trig_r <= 1'b0;
    end else begin
      gate_trig_r <= gate_rise || (gate_trig_r && !gt_tick && !wr_mode && !gt_stop);
    end
  end

  // ==========================================================================
  // Timer mode and load value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gt_mode_r <= counter_mode_zero;
      general_timer_count_r <= COUNT_RST;
    end else if (gt_stop) begin
      gt_mode_r <= counter_mode_one;
      general_timer_count_r <= COUNT_RST;
    end else begin
      if (wr_mode) begin
        gt_mode_r <= reg_wdata[MODE_W-1:0];
      end
      if (wr_count) begin
        general_timer_count_r <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // Timer counting sequence
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gt_state_r <= GT_IDLE;
      gt_count_r <= COUNT_RST;
      gt_out_r <= 1'b1;
    end else if (gt_stop) begin
      gt_state_r <= GT_IDLE;
      gt_count_r <= COUNT_RST;
      gt_out_r <= 1'b1;
    end else if (wr_mode) begin
      gt_state_r <= GT_IDLE;
      gt_out_r <= (reg_wdata[MODE_W-1:0] != counter_mode_zero);
    end else if (wr_count) begin
      gt_state_r <= GT_ARMED;
      if (gt_mode_r == counter_mode_zero) begin
        gt_out_r <= 1'b0;
      end
    end else if (gt_tick) begin
      if (pulse_mode) begin
        gt_out_r <= 1'b1;
      end
      unique case (gt_state_r)
        GT_IDLE: begin
        end
        GT_ARMED: begin
          if (!hw_trig_mode || gate_trig_r) begin
            gt_count_r <= general_timer_count_r;
            gt_state_r <= GT_RUN;
            if (gt_mode_r == counter_mode_one) begin
              gt_out_r <= 1'b0;
            end
          end
        end
        GT_RUN: begin
          if (hw_trig_mode && gate_trig_r) begin
            gt_count_r <= general_timer_count_r;
            if (gt_mode_r == counter_mode_one) begin
              gt_out_r <= 1'b0;
            end
          end else if ((gt_mode_r == counter_mode_two) || (gt_mode_r == counter_mode_three)) begin
            if (!gate_lvl) begin
              gt_out_r <= 1'b1;
            end else if (gate_trig_r) begin
              gt_count_r <= general_timer_count_r;
            end else if (gt_mode_r == counter_mode_two) begin
              if (gt_count_r <= ONE) begin
                gt_count_r <= general_timer_count_r;
                gt_out_r <= 1'b0;
              end else begin
                gt_count_r <= gt_count_r - ONE;
              end
            end else if (gt_count_r <= TWO) begin
              gt_count_r <= general_timer_count_r;
              gt_out_r <= !gt_out_r;
            end else begin
              gt_count_r <= gt_count_r - TWO;
            end
          end else if (hw_trig_mode || gate_lvl) begin
            gt_count_r <= gt_count_r - ONE;
            if (gt_count_r == ONE) begin
              gt_out_r <= (gt_mode_r == counter_mode_zero) || (gt_mode_r == counter_mode_one);
              gt_state_r <= hw_trig_mode ? GT_ARMED : GT_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign gt_out = gt_out_r;

  // Count at the moment of a stop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stop_count_r <= COUNT_RST;
    end else if (gt_stop) begin
      stop_count_r <= gt_count_r;
    end
  end

  // ==========================================================================
  // Read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (rst || !reg_rd) begin
      rdata_r <= '0;
    end else begin
      unique case (reg_addr)
        ADDR_DIV1: rdata_r <= first_pacer_divider_r;
        ADDR_DIV2: rdata_r <= second_pacer_divider_r;
        ADDR_CTRL: rdata_r <= DATA_W'({ext_sel_r, trig_en_r});
        ADDR_GT_MODE: rdata_r <= DATA_W'(gt_mode_r);
        ADDR_GT_COUNT: rdata_r <= gt_count_r;
        ADDR_SAMPLES: rdata_r <= samples_r;
        ADDR_STATUS: rdata_r <= DATA_W'({gt_state_r != GT_IDLE, trig_en_r, pif.running, gt_out_r});
        ADDR_STOP_COUNT: rdata_r <= stop_count_r;
        default: rdata_r <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_acq_stop_cmd;
    reg_wr && (reg_addr == ADDR_CMD) && reg_wdata[CMD_ACQ_STOP_BIT];
  endsequence

  sequence s_trigger_quiet;
    !trig_en_r && !pif.running ##1 !pacer_trig;
  endsequence

  property p_acq_stop;
    s_acq_stop_cmd |=> s_trigger_quiet;
  endproperty
  a_acq_stop: assert property (p_acq_stop) else $error("trigger alive after acquisition stop");

  property p_samples_kept;
    s_acq_stop_cmd and !reg_wdata[CMD_SAMPLES_CLR_BIT] and !sample_done |=> samples_r == $past(samples_r);
  endproperty
  a_samples_kept: assert property (p_samples_kept) else $error("sample tally lost on stop");

  property p_gt_stop;
    gt_stop |=> gt_out_r && (gt_mode_r == counter_mode_one) && (gt_count_r == COUNT_RST) &&
      (gt_state_r == GT_IDLE) && (stop_count_r == $past(gt_count_r));
  endproperty
  a_gt_stop: assert property (p_gt_stop) else $error("timer stop did not park and report");

  property p_readback;
    reg_rd && (reg_addr == ADDR_GT_COUNT) |=> reg_rdata == $past(gt_count_r);
  endproperty
  a_readback: assert property (p_readback) else $error("count readback mismatch");

  property p_mode0_terminal;
    (gt_state_r == GT_RUN) && (gt_mode_r == counter_mode_zero) && gt_tick && gate_lvl && !reg_wr &&
      (gt_count_r == ONE) |=> gt_out_r && (gt_state_r == GT_IDLE);
  endproperty
  a_mode0_terminal: assert property (p_mode0_terminal) else $error("mode zero terminal count missed");

  property p_ext_event;
    ext_sel_r && (gt_state_r == GT_RUN) && (gt_mode_r == counter_mode_zero) && gate_lvl && !reg_wr &&
      ext_rise && (gt_count_r > ONE) |=> gt_count_r == DATA_W'($past(gt_count_r) - ONE);
  endproperty
  a_ext_event: assert property (p_ext_event) else $error("external event not counted");

  property p_tick_spacing;
    tick_r |=> !tick_r ##1 !tick_r ##1 !tick_r;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("source tick too frequent");

  property p_zero_div;
    (first_pacer_divider_r == DIV_RST) || (second_pacer_divider_r == DIV_RST) |=> !pacer_trig;
  endproperty
  a_zero_div: assert property (p_zero_div) else $error("pacer trigger with zero divider");

endmodule : ptg_timer

// file: ptg_far_model.sv
// Far-side model: converter that answers pacer triggers, and an external event source.
// Assumes one clk_sys; every output changes just after its rising edge.
`timescale 1ns/1ps
module ptg_far_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Converter
  input wire logic pacer_trig,
  input wire logic [7:0] done_delay,
  output logic sample_done,
  // Event source
  input wire logic ext_en,
  input wire logic [7:0] ext_half,
  output logic gt_ext_clk_in
);
  logic busy_r;
  logic [7:0] wait_r;
  logic [7:0] ph_r;

  // ==========================================================================
  // Conversion: one done pulse a programmable delay after each trigger
  always_ff @(posedge clk_sys) begin
    sample_done <= 1'b0;
    if (rst) begin
      busy_r <= 1'b0;
      wait_r <= 8'h00;
    end else if (pacer_trig) begin
      busy_r <= 1'b1;
      wait_r <= done_delay;
    end else if (busy_r && wait_r == 8'h00) begin
      busy_r <= 1'b0;
      sample_done <= 1'b1;
    end else if (busy_r) begin
      wait_r <= wait_r - 8'h01;
    end
  end

  // ==========================================================================
  // Event clock: stands low unless enabled
  always_ff @(posedge clk_sys) begin
    if (rst || !ext_en) begin
      ph_r <= 8'h00;
      gt_ext_clk_in <= 1'b0;
    end else if (ph_r == ext_half - 8'h01) begin
      ph_r <= 8'h00;
      gt_ext_clk_in <= ~gt_ext_clk_in;
    end else begin
      ph_r <= ph_r + 8'h01;
    end
  end
endmodule : ptg_far_model

// file: pacer_and_general_timer_test.sv
// Self-checking bench for the pacer and general timer block.
// Assumes the far-side model supplies sample_done and the external timer clock.
`timescale 1ns/1ps
module pacer_and_general_timer_test;
  import ptg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic gt_ext_clk_in;
  logic gt_gate_in = 1'b0;
  logic gt_out;
  logic sample_done;
  logic pacer_trig;
  logic [7:0] done_delay = 8'h01;
  logic ext_en = 1'b0;
  logic [7:0] ext_half = 8'h04;
  logic trig_prev = 1'b0;
  int trig_seen = 0;
  int done_seen = 0;
  int mismatches = 0;
  int cmp_count = 0;

  always #20 clk_sys = ~clk_sys;

  ptg_timer DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gt_ext_clk_in(gt_ext_clk_in), .gt_gate_in(gt_gate_in),
    .gt_out(gt_out), .sample_done(sample_done), .pacer_trig(pacer_trig));
  ptg_far_model far (.clk_sys(clk_sys), .rst(rst), .pacer_trig(pacer_trig), .done_delay(done_delay),
    .sample_done(sample_done), .ext_en(ext_en), .ext_half(ext_half), .gt_ext_clk_in(gt_ext_clk_in));

  // ==========================================================================
  // Monitors
  always @(posedge clk_sys) begin
    if (trig_prev === 1'b1 && pacer_trig === 1'b1) begin
      mismatches++;
      $display("[FAIL] trigger width expected 1 seen 2");
    end
    if (pacer_trig === 1'b1) begin
      trig_seen++;
    end
    if (sample_done === 1'b1) begin
      done_seen++;
    end
    trig_prev = pacer_trig;
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk_sys);
    #1;
    chk("read data after its cycle", 16'h0000, reg_rdata);
  endtask : rd

  task automatic rc(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask : rc

  task automatic trig_in(input int n, output int c);
    int n0;
    n0 = trig_seen;
    repeat (n) @(posedge clk_sys);
    #1;
    c = trig_seen - n0;
  endtask : trig_in

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk("output at reset", 16'h0001, {15'h0000, gt_out});
    for (int a = 0; a < 10; a++) begin
      rc("reset value", ADDR_W'(a), (a == 7) ? 16'h0001 : 16'h0000);
    end
    wr(ADDR_DIV1, 16'hFFFF);
    rc("divider full width", ADDR_DIV1, 16'hFFFF);
  endtask : t_reset

  task automatic t_pacer();
    int n0;
    int k;
    int c;
    wr(ADDR_CMD, 16'h0004);
    done_seen = 0;
    wr(ADDR_DIV1, 16'h0003);
    wr(ADDR_DIV2, 16'h0007);
    wr(ADDR_CTRL, 16'h0001);
    n0 = trig_seen;
    k = 0;
    while (trig_seen == n0 && k < 2000) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("first trigger", 16'h0001, 16'(trig_seen - n0));
    trig_in(2100, c);
    chk("triggers in 168 ticks", 16'h0008, 16'(c));
    rc("pacer running", ADDR_STATUS, 16'h0007);
    @(posedge clk_sys);
    done_delay <= 8'h28;
    wr(ADDR_DIV1, 16'h0000);
    rc("pacer halted", ADDR_STATUS, 16'h0005);
    trig_in(600, c);
    chk("triggers with zero divider", 16'h0000, 16'(c));
    wr(ADDR_DIV1, 16'h0003);
    trig_in(600, c);
    chk("pacer resumed", 16'h0001, 16'(c > 0));
    wr(ADDR_CMD, 16'h0002);
    rc("trigger enable cleared", ADDR_CTRL, 16'h0000);
    trig_in(600, c);
    chk("triggers after stop", 16'h0000, 16'(c));
    rc("sample tally kept", ADDR_SAMPLES, 16'(done_seen));
  endtask : t_pacer

  task automatic t_modes();
    int falls;
    int n0;
    logic prev;
    n0 = trig_seen;
    for (int m = 0; m < 6; m++) begin
      @(posedge clk_sys);
      gt_gate_in <= 1'b0;
      wr(ADDR_GT_MODE, 16'(m));
      rc("mode readback", ADDR_GT_MODE, 16'(m));
      chk("output after mode", (m == 0) ? 16'h0000 : 16'h0001, {15'h0000, gt_out});
      wr(ADDR_GT_COUNT, 16'h0004);
      gt_gate_in <= 1'b1;
      #1;
      falls = 0;
      prev = gt_out;
      repeat (400) begin
        @(posedge clk_sys);
        #1;
        if (prev === 1'b1 && gt_out === 1'b0) falls++;
        prev = gt_out;
      end
      if (m == 2 || m == 3) begin
        chk("periodic low pulses", 16'h0001, 16'(falls >= 6));
      end else begin
        chk("single low phase", (m == 0) ? 16'h0000 : 16'h0001, 16'(falls));
        chk("output at rest", 16'h0001, {15'h0000, gt_out});
      end
    end
    wr(ADDR_GT_MODE, 16'h0006);
    rc("bad mode refused", ADDR_GT_MODE, 16'h0005);
    chk("timer makes no triggers", 16'h0000, 16'(trig_seen - n0));
  endtask : t_modes

  task automatic t_ext();
    wr(ADDR_CTRL, 16'h0002);
    wr(ADDR_GT_MODE, 16'h0000);
    wr(ADDR_GT_COUNT, 16'h0064);
    repeat (200) @(posedge clk_sys);
    ext_en <= 1'b1;
    repeat (80) @(posedge clk_sys);
    ext_en <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rc("events counted", ADDR_GT_COUNT, 16'h005B);
    repeat (200) @(posedge clk_sys);
    rc("count holds without events", ADDR_GT_COUNT, 16'h005B);
  endtask : t_ext

  task automatic t_stop();
    logic [DATA_W-1:0] c;
    logic [DATA_W-1:0] s;
    int lows;
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_GT_MODE, 16'h0002);
    wr(ADDR_GT_COUNT, 16'h03E8);
    repeat (300) @(posedge clk_sys);
    rd(ADDR_GT_COUNT, c);
    chk("count running", 16'h0001, 16'(c < 16'h03E8 && c > 16'h03C0));
    wr(ADDR_CMD, 16'h0001);
    rd(ADDR_STOP_COUNT, s);
    chk("stop count reported", 16'h0001, 16'(s === c || s === c - 16'h0001));
    rc("mode after stop", ADDR_GT_MODE, 16'h0001);
    rc("count after stop", ADDR_GT_COUNT, 16'h0000);
    rc("status after stop", ADDR_STATUS, 16'h0001);
    lows = 0;
    repeat (300) begin
      @(posedge clk_sys);
      #1;
      if (gt_out !== 1'b1) lows++;
    end
    chk("output parked high", 16'h0000, 16'(lows));
  endtask : t_stop

  // ==========================================================================
  // Verdict and main sequence
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_pacer();
    t_modes();
    t_ext();
    t_stop();
    summarize();
  end
endmodule : pacer_and_general_timer_test
